// ==== hw/pti_top.v ====
// Trigger, trip and interrupt interconnect around nine modulator modules
// Notes on behaviour
// RQ1: Module one sync output is stretched to 8 clocks before the pin multiplexer.
// RQ2: Nine conv-start-A outputs are OR-ed and stretched to 32 clocks.
// RQ3: Nine conv-start-B outputs are OR-ed and stretched to 32 clocks.
// RQ4: All 18 conv-start outputs go unmerged to the analog subsystem.
// RQ5: Sync inputs come from external sync on trip line one and timebase bit.
// RQ6: Fifteen trip events: twelve trip lines, RAM double-bit error, expander error.
// RQ7: Six trip zones: trip lines one to three, encoder, clock loss, debug halt.
// RQ8: Each module drives an event interrupt and a trip interrupt to the expander.
// RQ9: Modules one to eight have fine-edge placement; module nine does not.
// RQ10: Stretchers are reloaded down-counters; new events extend the pulse.
`timescale 1ns/1ps
`default_nettype none
`include "pti_defs.vh"
module pti_top (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire [11:0] gp_trip_lines,
    input  wire        timebase_clock_sync_bit,
    input  wire        ram_double_bit_error,
    input  wire        irq_expander_error,
    input  wire        encoder_module_error,
    input  wire        clock_loss_flag,
    input  wire        debug_halt,
    input  wire        module_one_sync_out,
    input  wire [8:0]  conv_start_a,
    input  wire [8:0]  conv_start_b,
    input  wire [8:0]  mod_event_irq_in,
    input  wire [8:0]  mod_trip_irq_in,
    output wire        external_sync_in,
    output wire        timebase_sync_out,
    output wire [14:0] trip_event_inputs,
    output wire [5:0]  trip_zone_inputs,
    output wire        sync_to_pin_mux,
    output wire        merged_conv_start_a_out,
    output wire        merged_conv_start_b_out,
    output wire [17:0] conv_start_to_analog,
    output wire [8:0]  modulator_event_irq,
    output wire [8:0]  modulator_trip_irq,
    output wire [8:0]  fine_edge_enable
);

    // ----------------------------------------
    // Internal registers and next values
    // ----------------------------------------
    // Every routed output except the constant fine_edge_enable leaves from a flip-flop
    reg         ext_sync_q;
    wire        ext_sync_d;
    reg         tb_sync_q;
    wire        tb_sync_d;
    reg  [14:0] trip_ev_q;
    wire [14:0] trip_ev_d;
    reg  [5:0]  trip_zone_q;
    wire [5:0]  trip_zone_d;
    reg  [17:0] analog_q;
    wire [17:0] analog_d;
    reg  [8:0]  event_irq_q;
    wire [8:0]  event_irq_d;
    reg  [8:0]  trip_irq_q;
    wire [8:0]  trip_irq_d;

    // Shared trigger requests before stretching
    wire        conv_any_a;
    wire        conv_any_b;

    genvar      t;
    genvar      z;
    genvar      m;

    // ----------------------------------------
    // Synchronization sources
    // ----------------------------------------
    // External sync is trip line one; the timebase bit passes as a level
    assign ext_sync_d = gp_trip_lines[0]; // RQ5
    assign tb_sync_d  = timebase_clock_sync_bit; // RQ5

    // ----------------------------------------
    // Trip event sources
    // ----------------------------------------
    // Twelve trip lines fill the low inputs in order
    generate
        for (t = 0; t < `PTI_NUM_GP_TRIP; t = t + 1) begin : g_trip_ev
            assign trip_ev_d[t] = gp_trip_lines[t]; // RQ6
        end
    endgenerate

    // Memory and expander errors take the next two inputs
    assign trip_ev_d[12] = ram_double_bit_error; // RQ6
    assign trip_ev_d[13] = irq_expander_error; // RQ6

    // Fourteen sources for fifteen inputs: the top one is held inactive
    assign trip_ev_d[14] = 1'b0;

    // ----------------------------------------
    // Trip zone sources
    // ----------------------------------------
    // First three trip lines, then the three fault sources
    generate
        for (z = 0; z < 3; z = z + 1) begin : g_trip_zone
            assign trip_zone_d[z] = gp_trip_lines[z]; // RQ7
        end
    endgenerate

    assign trip_zone_d[3] = encoder_module_error; // RQ7
    assign trip_zone_d[4] = clock_loss_flag; // RQ7
    assign trip_zone_d[5] = debug_halt; // RQ7

    // ----------------------------------------
    // Per-module routing
    // ----------------------------------------
    // Bit m of every nine-bit bus belongs to module m+1
    generate
        for (m = 0; m < `PTI_NUM_MOD; m = m + 1) begin : g_mod
            // Starts go out unmerged, A half below B half
            assign analog_d[m]                = conv_start_a[m]; // RQ4
            assign analog_d[m + `PTI_NUM_MOD] = conv_start_b[m]; // RQ4

            // Two separate requests per module
            assign event_irq_d[m] = mod_event_irq_in[m]; // RQ8
            assign trip_irq_d[m]  = mod_trip_irq_in[m]; // RQ8

            // Capability is fixed; the last module is standard resolution only
            assign fine_edge_enable[m] = (m < `PTI_NUM_FINE_MOD) ? 1'b1 : 1'b0; // RQ9
        end
    endgenerate

    // ----------------------------------------
    // Conversion start merge
    // ----------------------------------------
    // Any module raising its start fires the shared trigger
    assign conv_any_a = |conv_start_a; // RQ2
    assign conv_any_b = |conv_start_b; // RQ3

    // ----------------------------------------
    // Stretchers
    // ----------------------------------------
    // Retriggering lets close events merge into one longer pulse
    // Sync takes the short count, the merged starts the long one
    pti_stretch #(.LEN(`PTI_SYNC_STRETCH)) u_sync (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .pulse_in  (module_one_sync_out),
        .pulse_out (sync_to_pin_mux)
    ); // RQ1

    pti_stretch #(.LEN(`PTI_CONV_STRETCH)) u_conv_start_a (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .pulse_in  (conv_any_a),
        .pulse_out (merged_conv_start_a_out)
    ); // RQ2

    pti_stretch #(.LEN(`PTI_CONV_STRETCH)) u_conv_start_b (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .pulse_in  (conv_any_b),
        .pulse_out (merged_conv_start_b_out)
    ); // RQ3

    // ----------------------------------------
    // Sync registers
    // ----------------------------------------
    // One stage keeps routes aligned with the stretched outputs
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sync_q <= 1'b0;
            tb_sync_q  <= 1'b0;
        end else if (clk_en) begin
            ext_sync_q <= ext_sync_d;
            tb_sync_q  <= tb_sync_d;
        end
    end

    // ----------------------------------------
    // Trip registers
    // ----------------------------------------
    // Low enable holds every trip input at its last value
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trip_ev_q   <= 15'h0000;
            trip_zone_q <= 6'h00;
        end else if (clk_en) begin
            trip_ev_q   <= trip_ev_d;
            trip_zone_q <= trip_zone_d;
        end
    end

    // ----------------------------------------
    // Module registers
    // ----------------------------------------
    // Adds one cycle of latency to triggers and interrupts alike
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            analog_q    <= 18'h00000;
            event_irq_q <= 9'h000;
            trip_irq_q  <= 9'h000;
        end else if (clk_en) begin
            analog_q    <= analog_d;
            event_irq_q <= event_irq_d;
            trip_irq_q  <= trip_irq_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Straight from the flip-flops, no logic after them
    assign external_sync_in     = ext_sync_q;
    assign timebase_sync_out    = tb_sync_q;

    assign trip_event_inputs    = trip_ev_q;
    assign trip_zone_inputs     = trip_zone_q;

    assign conv_start_to_analog = analog_q;
    assign modulator_event_irq  = event_irq_q;
    assign modulator_trip_irq   = trip_irq_q;
endmodule
`default_nettype wire

// ==== hw/pti_defs.vh ====
// Constants for the modulator trigger interconnect
`ifndef PTI_DEFS_VH
`define PTI_DEFS_VH
`define PTI_NUM_MOD        9
`define PTI_NUM_GP_TRIP    12
`define PTI_NUM_TRIP_EV    15
`define PTI_NUM_TRIP_ZONE  6
`define PTI_NUM_FINE_MOD   8
`define PTI_SYNC_STRETCH   6'h08
`define PTI_CONV_STRETCH   6'h20
`define PTI_CNT_W          6
`endif

// ==== hw/pti_stretch.v ====
// Retriggerable pulse stretcher built on a reloaded down-counter
`timescale 1ns/1ps
`default_nettype none
`include "pti_defs.vh"
module pti_stretch #(
    parameter [5:0] LEN = `PTI_SYNC_STRETCH
) (
    input  wire clock,
    input  wire sys_rst,
    input  wire clk_en,
    input  wire pulse_in,
    output wire pulse_out
);
    reg  [5:0] count_q;
    wire [5:0] count_d;
    reg        out_q;
    wire       out_d;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Reload on every input so a new event extends the pulse
    assign count_d = pulse_in ? LEN :
                     (count_q != 6'h00) ? count_q - 6'h01 : 6'h00; // RQ10

    // Registered output: high exactly LEN cycles after the last input
    assign out_d = pulse_in | (count_q > 6'h01); // RQ10

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= 6'h00;
            out_q   <= 1'b0;
        end else if (clk_en) begin
            count_q <= count_d;
            out_q   <= out_d;
        end
    end

    assign pulse_out = out_q;
endmodule
`default_nettype wire

// ==== testbench/pti_top_monitor.sv ====
// Stretcher checks bound into the top
`timescale 1ns/1ps
`default_nettype none
module pti_top_monitor (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       clk_en,
    input wire logic       module_one_sync_out,
    input wire logic       sync_to_pin_mux,
    input wire logic       merged_conv_start_a_out,
    input wire logic       merged_conv_start_b_out,
    input wire logic [8:0] conv_start_a,
    input wire logic [8:0] conv_start_b
);
    wire si = module_one_sync_out, so = sync_to_pin_mux, ai = |conv_start_a;
    wire ao = merged_conv_start_a_out, bi = |conv_start_b, bo = merged_conv_start_b_out;
    default clocking @(posedge clock); endclocking
    // Low enable freezes the design, so the checks pause with it
    default disable iff (sys_rst || !clk_en);
    sync_len_a: assert property (si |=> so [*8]) else $error("sync");
    sync_idle_a: assert property (!si && !so |=> !so) else $error("sync");
    conv_a_len_a: assert property (ai |-> ##32 ao) else $error("conv a");
    conv_a_rise_a: assert property (ai |=> ao) else $error("conv a");
    conv_a_idle_a: assert property (!ai && !ao |=> !ao) else $error("conv a");
    conv_b_len_a: assert property (bi |-> ##32 bo) else $error("conv b");
    conv_b_rise_a: assert property (bi |=> bo) else $error("conv b");
    conv_b_idle_a: assert property (!bi && !bo |=> !bo) else $error("conv b");
    // Cycles since the last event, saturating one past the stretch length
    logic [5:0] a_age_q, b_age_q;
    logic [3:0] s_age_q;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            a_age_q <= 6'h21;
            b_age_q <= 6'h21;
            s_age_q <= 4'h9;
        end else if (clk_en) begin
            a_age_q <= ai ? 6'h01 : (a_age_q < 6'h21) ? a_age_q + 6'h01 : a_age_q;
            b_age_q <= bi ? 6'h01 : (b_age_q < 6'h21) ? b_age_q + 6'h01 : b_age_q;
            s_age_q <= si ? 4'h1 : (s_age_q < 4'h9) ? s_age_q + 4'h1 : s_age_q;
        end
    end
    sync_exact_a: assert property (so == (s_age_q <= 4'h8)) else $error("sync length");
    conv_a_exact_a: assert property (ao == (a_age_q <= 6'h20)) else $error("conv a length");
    conv_b_exact_a: assert property (bo == (b_age_q <= 6'h20)) else $error("conv b length");
    cover property (si ##1 !si);
    cover property (ai ##3 ai);
    cover property ($fell(bo));
endmodule
bind pti_top pti_top_monitor u_mon (.*);
`default_nettype wire

// ==== testbench/pti_mod_bank.sv ====
// Modulator bank stand-in
`timescale 1ns/1ps
`default_nettype none
module pti_mod_bank (input wire logic clock, go, input wire logic [8:0] pat,
    output logic module_one_sync_out, output logic [8:0] conv_start_a, conv_start_b,
    output logic [8:0] mod_event_irq_in, mod_trip_irq_in);
    // B side rotated so a swapped half shows up
    always @(posedge clock) begin
        {module_one_sync_out, conv_start_a, mod_event_irq_in} <= go ? {pat[0], pat, pat} : 19'h0;
        {conv_start_b, mod_trip_irq_in} <= go ? {2{pat[0], pat[8:1]}} : 18'h0;
    end
endmodule
`default_nettype wire

// ==== testbench/pti_top_tb.sv ====
// Bench for the trigger interconnect
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected %0t %h", $time, a); end end
module pti_top_tb;
    logic clock = 0, sys_rst = 1, clk_en = 1, go = 0, timebase_clock_sync_bit = 0;
    logic ram_double_bit_error = 0, irq_expander_error = 0, encoder_module_error = 0;
    logic clock_loss_flag = 0, debug_halt = 0, module_one_sync_out, sync_to_pin_mux;
    logic external_sync_in, timebase_sync_out, merged_conv_start_a_out, merged_conv_start_b_out;
    logic [8:0] pat = 9'h000, conv_start_a, conv_start_b, mod_event_irq_in, mod_trip_irq_in;
    logic [8:0] modulator_event_irq, modulator_trip_irq, fine_edge_enable;
    logic [11:0] gp_trip_lines = 12'h000;
    logic [14:0] trip_event_inputs;
    logic [5:0] trip_zone_inputs;
    logic [17:0] conv_start_to_analog;
    int err_total = 0, n_checks = 0;
    pti_top u_dut (.*);
    pti_mod_bank u_far (.*);
    initial forever #2.5 clock = ~clock;
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic route;
        gp_trip_lines = 12'hA5D;
        {timebase_clock_sync_bit, irq_expander_error, encoder_module_error, debug_halt} = 4'hF;
        step(1);
        `CHK({external_sync_in, timebase_sync_out, trip_zone_inputs}, 8'hED)
        `CHK({trip_event_inputs, fine_edge_enable}, 24'h54BAFF)
        gp_trip_lines = 12'h5A2;
        {timebase_clock_sync_bit, irq_expander_error, encoder_module_error, debug_halt} = 4'h0;
        {ram_double_bit_error, clock_loss_flag} = 2'h3;
        step(1);
        `CHK({external_sync_in, timebase_sync_out, trip_zone_inputs}, 8'h12)
        `CHK({trip_event_inputs, fine_edge_enable}, 24'h2B44FF)
        $display("route test done");
    endtask
    // Second event at cycle g must extend, not restart short
    task automatic pulses(logic [8:0] p, int g);
        int na = 0, nb = 0, ns = 0;
        logic [35:0] y;
        pat = p;
        for (int i = 0; i < 50; i++) begin
            go = (i == 0 || i == g);
            step(1);
            if (i == 1) y = {modulator_trip_irq, modulator_event_irq, conv_start_to_analog};
            na += (merged_conv_start_a_out === 1'b1);
            nb += (merged_conv_start_b_out === 1'b1);
            ns += (sync_to_pin_mux === 1'b1);
        end
        `CHK(y, {2{p[0], p[8:1], p}})
        `CHK({na, nb, ns}, {32 + g, 32 + g, p[0] ? 8 + g : 0})
        $display("pulse test done");
    endtask
    // Low enable holds counts and routes; a reset mid-pulse clears everything
    task automatic freeze;
        int na = 0, ns = 0;
        logic [61:0] all_q;
        pat = 9'h001;
        go = 1;
        step(1);
        go = 0;
        step(3);
        clk_en = 0;
        gp_trip_lines = 12'hFFF;
        step(40);
        `CHK({sync_to_pin_mux, merged_conv_start_a_out, trip_event_inputs}, 17'h195A2)
        clk_en = 1;
        for (int i = 0; i < 40; i++) begin
            step(1);
            na += (merged_conv_start_a_out === 1'b1);
            ns += (sync_to_pin_mux === 1'b1);
        end
        `CHK({na, ns}, {32'd29, 32'd5})
        go = 1;
        step(3);
        go = 0;
        sys_rst = 1;
        step(1);
        all_q = {sync_to_pin_mux, merged_conv_start_a_out, merged_conv_start_b_out,
                 external_sync_in, timebase_sync_out, trip_zone_inputs, trip_event_inputs,
                 conv_start_to_analog, modulator_event_irq, modulator_trip_irq};
        `CHK(all_q, 62'h0)
        sys_rst = 0;
        step(1);
        `CHK({sync_to_pin_mux, merged_conv_start_a_out, merged_conv_start_b_out}, 3'h0)
        `CHK(trip_event_inputs, 15'h1FFF)
        step(1);
        `CHK({sync_to_pin_mux, merged_conv_start_a_out, merged_conv_start_b_out}, 3'h0)
        $display("freeze test done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(6);
        sys_rst = 0;
        step(2);
        route;
        pulses(9'h008, 0);
        pulses(9'h100, 10);
        pulses(9'h1FF, 3);
        freeze;
        close_out;
    end
    initial begin
        #100000;
        err_total++;
        close_out;
    end
endmodule
`default_nettype wire
